/* shared/vcdt_pkg.sv */
// Purpose: shared constants for the valley count dead time sequencer
// Assumes: 25 MHz system clock
// Notes: times are kept in ns, cycle counts derive from them
package vcdt_pkg;
  localparam int CLK_MHZ = 25;
  // total dead time clamp, longest time: round down
  localparam int DT_CLAMP_NS = 36500;
  localparam logic [9:0] DT_CLAMP_CYC = 10'(DT_CLAMP_NS * CLK_MHZ / 1000);
  // extra dead time at the lowest control level
  localparam int EDT_MAX_NS = 20000;
  localparam int EDT_LEVEL_MAX = 31;
  localparam logic [9:0] EDT_STEP_CYC = 10'(EDT_MAX_NS * CLK_MHZ / 1000 / EDT_LEVEL_MAX);
  // watchdog restart, default of a top-level parameter
  localparam int WDOG_NS = 200000;
  localparam int WDOG_CYC = WDOG_NS * CLK_MHZ / 1000;
  // substitute edge margins, least times: round up
  localparam int SUB2_NS = 1000;
  localparam logic [10:0] SUB2_CYC = 11'((SUB2_NS * CLK_MHZ + 999) / 1000);
  localparam int SUB3_NS = 250;
  localparam logic [10:0] SUB3_CYC = 11'((SUB3_NS * CLK_MHZ + 999) / 1000);
  // probe settling before the comparators are sampled
  localparam int PROBE_NS = 10000;
  localparam logic [8:0] PROBE_CYC = 9'((PROBE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [2:0] VALLEY_MIN = 3'h1;
  localparam logic [2:0] VALLEY_MAX = 3'h6;
  // register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_INTERVAL = 8'h08;
  localparam logic [31:0] CTRL_RESET = 32'h0;
  localparam int CTRL_UNSYNC_BIT = 0;
  localparam int ST_VALLEY_LSB = 0;
  localparam int ST_EDT_BIT = 3;
  localparam int ST_RCODE_LSB = 4;
  localparam int ST_OPEN_BIT = 6;
  localparam int ST_SHORT_BIT = 7;
  localparam int ST_RUN_BIT = 8;
  localparam int ST_IVALID_BIT = 9;
  // resistor codes: 150, 330, 620, 1000 ohm
  localparam logic [1:0] RCODE_150 = 2'h0;
  localparam logic [1:0] RCODE_330 = 2'h1;
  localparam logic [1:0] RCODE_620 = 2'h2;
  localparam logic [1:0] RCODE_1000 = 2'h3;
  localparam int SYNC_W = 16;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PROBE = 3'b001,
    ST_FAULT = 3'b010,
    ST_WAIT_OFF = 3'b011,
    ST_COUNT = 3'b100,
    ST_EDT = 3'b101,
    ST_SYNC = 3'b110
  } vcdt_state_type;
endpackage : vcdt_pkg

/* hw/vcdt_sync.sv */
// Purpose: two-flop synchroniser for the sense and comparator inputs
// Assumes: one clock
// Notes: first stage is read by the second stage only
`timescale 1ns/1ps
`default_nettype none
module vcdt_sync #(
  parameter int W = vcdt_pkg::SYNC_W
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      meta_r <= '0;
      q_out <= '0;
    end else begin
      meta_r <= d_in;
      q_out <= meta_r;
    end
  end
endmodule : vcdt_sync
`default_nettype wire

/* hw/vcdt_ctrl.sv */
// Purpose: valley count foldback, extra dead time and sense resistor probe
// Assumes: comparator outputs arrive per boundary, apb master
// Notes: one switching cycle runs from on_time_end to switch_on
//
// What this block does
// - run critical conduction, first valley turn-on, above the selected foldback threshold
// - valley number rises as demand falls, at most six, turn-on at valley
// - three-bit counter counts demag falling edges up to the selected valley number
// - at six valleys below the fifth falling foldback threshold append extra dead time
// - extra dead time grows as control level falls, about 20 us maximum
// - after extra dead time wait for a demag edge unless unsync is set
// - total dead time clamped to 36.5 us, forcing turn-on
// - valley number steps by one only and holds inside its window
// - leaving and entering a valley number use different thresholds
// - watchdog forces turn-on 200 us after the cycle without demag
// - record first-to-second edge interval, substitute second edge after interval plus 1 us
// - later edges substituted after interval plus 250 ns
// - identify sense resistor after supply on, before switching, store result
// - probe source enabled during identification, comparators give resistor code
// - resistor code selects the falling foldback threshold
// - probe above highest reference latches open fault until supply reset
// - probe below lowest reference latches short fault until supply reset
// - valley number chosen from six windows with hysteresis between neighbours
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module vcdt_ctrl #(
  parameter int WDOG_CYC = vcdt_pkg::WDOG_CYC
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic supply_on,
  input wire logic supply_reset,
  input wire logic demag_sense,
  input wire logic on_time_end,
  input wire logic [4:0] fold_below_fall,
  input wire logic [4:0] fold_above_rise,
  input wire logic [4:0] edt_level,
  input wire logic [4:0] probe_above_ref,
  output logic sense_resistor_probe_on,
  output logic [1:0] foldback_select,
  output logic switch_on,
  output logic switching_enabled
);
  vcdt_pkg::vcdt_state_type st_r;
  logic [15:0] sync_q;
  logic demag_q, demag_d_r, zcd_fall, subst_fire, edge_evt, fire, edt_go, unsync;
  logic [4:0] below_q, above_q, probe_q;
  logic [2:0] valley_r, edge_cnt_r;
  logic [9:0] dt_cnt_r, edt_cnt_r, interval_r, edt_load;
  logic [10:0] gap_cnt_r, gap_lim;
  logic [12:0] wd_cnt_r;
  logic [8:0] probe_cnt_r;
  logic [1:0] rcode_r;
  logic open_r, short_r, ivalid_r, subst_seen_r;
  logic [31:0] ctrl_r;
  logic wr_en, hit;

  // rule-checked inputs pass through two flops first
  vcdt_sync #(.W(vcdt_pkg::SYNC_W)) u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .d_in({demag_sense, fold_below_fall, fold_above_rise, probe_above_ref}),
    .q_out(sync_q)
  );
  assign demag_q = sync_q[15];
  assign below_q = sync_q[14:10];
  assign above_q = sync_q[9:5];
  assign probe_q = sync_q[4:0];

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      demag_d_r <= 1'b0;
    end else begin
      demag_d_r <= demag_q;
    end
  end
  assign zcd_fall = demag_d_r & ~demag_q;

  // substitute edge once ringing is too weak to see
  assign gap_lim = {1'b0, interval_r} + ((edge_cnt_r == 3'h1) ? vcdt_pkg::SUB2_CYC : vcdt_pkg::SUB3_CYC);
  assign subst_fire = ivalid_r && !zcd_fall && edge_cnt_r != 3'h0 && gap_cnt_r == gap_lim &&
                      (st_r == vcdt_pkg::ST_COUNT || st_r == vcdt_pkg::ST_SYNC);
  assign edge_evt = zcd_fall | subst_fire;
  assign unsync = ctrl_r[vcdt_pkg::CTRL_UNSYNC_BIT];
  assign edt_load = 10'(edt_level) * vcdt_pkg::EDT_STEP_CYC;
  assign edt_go = valley_r == vcdt_pkg::VALLEY_MAX && below_q[4] && edt_load != 10'h0;

  // turn-on request for this cycle
  always_comb begin
    fire = 1'b0;
    case (st_r)
      vcdt_pkg::ST_COUNT: begin
        if (edge_cnt_r == 3'h0) begin
          fire = wd_cnt_r == 13'(WDOG_CYC - 1) && !edge_evt;
        end else if (dt_cnt_r == vcdt_pkg::DT_CLAMP_CYC - 10'h1) begin
          fire = 1'b1;
        end
        if (edge_evt && edge_cnt_r + 3'h1 == valley_r && !edt_go) begin
          fire = 1'b1;
        end
      end
      vcdt_pkg::ST_EDT: begin
        fire = (edt_cnt_r == 10'h1 && unsync) || dt_cnt_r == vcdt_pkg::DT_CLAMP_CYC - 10'h1;
      end
      vcdt_pkg::ST_SYNC: begin
        fire = edge_evt || dt_cnt_r == vcdt_pkg::DT_CLAMP_CYC - 10'h1;
      end
      default: fire = 1'b0;
    endcase
  end

  // sequencer
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_r <= vcdt_pkg::ST_IDLE;
    end else if (supply_reset) begin
      st_r <= vcdt_pkg::ST_IDLE;
    end else begin
      case (st_r)
        vcdt_pkg::ST_IDLE: if (supply_on) st_r <= vcdt_pkg::ST_PROBE;
        vcdt_pkg::ST_PROBE: begin
          if (probe_cnt_r == vcdt_pkg::PROBE_CYC - 9'h1) begin
            st_r <= (probe_q[4] || !probe_q[0]) ? vcdt_pkg::ST_FAULT : vcdt_pkg::ST_WAIT_OFF;
          end
        end
        vcdt_pkg::ST_FAULT: st_r <= vcdt_pkg::ST_FAULT;
        vcdt_pkg::ST_WAIT_OFF: if (on_time_end) st_r <= vcdt_pkg::ST_COUNT;
        vcdt_pkg::ST_COUNT: begin
          if (fire) begin
            st_r <= vcdt_pkg::ST_WAIT_OFF;
          end else if (edge_evt && edge_cnt_r + 3'h1 == valley_r) begin
            st_r <= vcdt_pkg::ST_EDT;
          end
        end
        vcdt_pkg::ST_EDT: begin
          if (fire) begin
            st_r <= vcdt_pkg::ST_WAIT_OFF;
          end else if (edt_cnt_r == 10'h1) begin
            st_r <= vcdt_pkg::ST_SYNC;
          end
        end
        vcdt_pkg::ST_SYNC: if (fire) st_r <= vcdt_pkg::ST_WAIT_OFF;
        default: st_r <= vcdt_pkg::ST_IDLE;
      endcase
    end
  end

  // identification: probe timer, resistor code, latched pin faults
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      probe_cnt_r <= 9'h0;
      rcode_r <= vcdt_pkg::RCODE_1000;
      open_r <= 1'b0;
      short_r <= 1'b0;
    end else if (supply_reset) begin
      probe_cnt_r <= 9'h0;
      open_r <= 1'b0;
      short_r <= 1'b0;
    end else if (st_r == vcdt_pkg::ST_PROBE) begin
      probe_cnt_r <= probe_cnt_r + 9'h1;
      if (probe_cnt_r == vcdt_pkg::PROBE_CYC - 9'h1) begin
        open_r <= probe_q[4];
        short_r <= !probe_q[0];
        // thermometer code from the reference comparators
        if (probe_q[3]) rcode_r <= vcdt_pkg::RCODE_1000;
        else if (probe_q[2]) rcode_r <= vcdt_pkg::RCODE_620;
        else if (probe_q[1]) rcode_r <= vcdt_pkg::RCODE_330;
        else rcode_r <= vcdt_pkg::RCODE_150;
      end
    end
  end

  // valley number, moved only at turn-on so it stays locked within a cycle
  always_ff @(posedge clk_sys) begin
    if (reset || st_r == vcdt_pkg::ST_IDLE) begin
      valley_r <= vcdt_pkg::VALLEY_MIN;
    end else if (fire) begin
      if (valley_r < vcdt_pkg::VALLEY_MAX && below_q[valley_r - 3'h1]) begin
        valley_r <= valley_r + 3'h1;
      end else if (valley_r > vcdt_pkg::VALLEY_MIN && above_q[valley_r - 3'h2]) begin
        valley_r <= valley_r - 3'h1;
      end
    end
  end

  // edge count, dead time clamp, extra dead time, gap and watchdog timers
  always_ff @(posedge clk_sys) begin
    if (reset || st_r == vcdt_pkg::ST_WAIT_OFF || st_r == vcdt_pkg::ST_IDLE) begin
      edge_cnt_r <= 3'h0;
      dt_cnt_r <= 10'h0;
      edt_cnt_r <= 10'h0;
      gap_cnt_r <= 11'h0;
      wd_cnt_r <= 13'h0;
      subst_seen_r <= 1'b0;
    end else begin
      if (edge_evt && edge_cnt_r != 3'h7) edge_cnt_r <= edge_cnt_r + 3'h1;
      if (edge_cnt_r != 3'h0 && dt_cnt_r != vcdt_pkg::DT_CLAMP_CYC) dt_cnt_r <= dt_cnt_r + 10'h1;
      if (st_r == vcdt_pkg::ST_COUNT && edge_evt && edge_cnt_r + 3'h1 == valley_r) begin
        edt_cnt_r <= edt_load;
      end else if (edt_cnt_r != 10'h0) begin
        edt_cnt_r <= edt_cnt_r - 10'h1;
      end
      if (edge_evt) gap_cnt_r <= 11'h0;
      else if (gap_cnt_r != 11'h7ff) gap_cnt_r <= gap_cnt_r + 11'h1;
      if (wd_cnt_r != 13'h1fff) wd_cnt_r <= wd_cnt_r + 13'h1;
      if (subst_fire) subst_seen_r <= 1'b1;
    end
  end

  // last reliable interval: second edge natural and in range
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      interval_r <= 10'h0;
      ivalid_r <= 1'b0;
    end else if (zcd_fall && edge_cnt_r == 3'h1 && !subst_seen_r && gap_cnt_r < 11'h400) begin
      interval_r <= gap_cnt_r[9:0];
      ivalid_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      switch_on <= 1'b0;
    end else begin
      // first pulse after a clean probe starts switching
      switch_on <= fire || (st_r == vcdt_pkg::ST_PROBE && !supply_reset &&
                   probe_cnt_r == vcdt_pkg::PROBE_CYC - 9'h1 && !probe_q[4] && probe_q[0]);
    end
  end

  assign sense_resistor_probe_on = st_r == vcdt_pkg::ST_PROBE;
  assign foldback_select = rcode_r;
  assign switching_enabled = st_r[2] || st_r == vcdt_pkg::ST_WAIT_OFF;

  // apb slave, zero wait states
  assign hit = paddr == vcdt_pkg::REG_CTRL || paddr == vcdt_pkg::REG_STATUS || paddr == vcdt_pkg::REG_INTERVAL;
  assign wr_en = psel && penable && pwrite && paddr == vcdt_pkg::REG_CTRL;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl_r <= vcdt_pkg::CTRL_RESET;
    end else if (wr_en) begin
      ctrl_r <= {31'h0, pwdata[vcdt_pkg::CTRL_UNSYNC_BIT]};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      prdata <= 32'h0;
    end else if (psel && !penable) begin
      prdata <= 32'h0;
      case (paddr)
        vcdt_pkg::REG_CTRL: prdata <= ctrl_r;
        vcdt_pkg::REG_STATUS: begin
          prdata[vcdt_pkg::ST_VALLEY_LSB +: 3] <= valley_r;
          prdata[vcdt_pkg::ST_EDT_BIT] <= st_r == vcdt_pkg::ST_EDT;
          prdata[vcdt_pkg::ST_RCODE_LSB +: 2] <= rcode_r;
          prdata[vcdt_pkg::ST_OPEN_BIT] <= open_r;
          prdata[vcdt_pkg::ST_SHORT_BIT] <= short_r;
          prdata[vcdt_pkg::ST_RUN_BIT] <= switching_enabled;
          prdata[vcdt_pkg::ST_IVALID_BIT] <= ivalid_r;
        end
        vcdt_pkg::REG_INTERVAL: prdata <= {22'h0, interval_r};
        default: prdata <= 32'h0;
      endcase
    end
  end

  a_valley_range: assert property (@(posedge clk_sys) disable iff (reset)
    valley_r >= vcdt_pkg::VALLEY_MIN && valley_r <= vcdt_pkg::VALLEY_MAX)
    else $error("valley number out of range");
  a_valley_step: assert property (@(posedge clk_sys) disable iff (reset)
    $changed(valley_r) && $past(st_r) != vcdt_pkg::ST_IDLE |->
    $past(fire) && (valley_r == $past(valley_r) + 3'h1 || valley_r == $past(valley_r) - 3'h1))
    else $error("valley number jumped or moved outside turn-on");
  a_count_turn_on: assert property (@(posedge clk_sys) disable iff (reset || supply_reset)
    st_r == vcdt_pkg::ST_COUNT && edge_evt && edge_cnt_r + 3'h1 == valley_r && !edt_go |=> switch_on)
    else $error("no turn-on when valley count reached");
  a_first_valley: assert property (@(posedge clk_sys) disable iff (reset || supply_reset)
    st_r == vcdt_pkg::ST_COUNT && valley_r == 3'h1 && zcd_fall && edge_cnt_r == 3'h0 |=>
    switch_on ##1 st_r == vcdt_pkg::ST_WAIT_OFF)
    else $error("critical conduction missed first valley");
  a_clamp_limit: assert property (@(posedge clk_sys) disable iff (reset)
    dt_cnt_r == vcdt_pkg::DT_CLAMP_CYC - 10'h1 && st_r[2] && !supply_reset |=> switch_on)
    else $error("dead time clamp not enforced");
  a_watchdog: assert property (@(posedge clk_sys) disable iff (reset || supply_reset)
    st_r == vcdt_pkg::ST_COUNT && edge_cnt_r == 3'h0 && !edge_evt && wd_cnt_r == 13'(WDOG_CYC - 1) |=> switch_on)
    else $error("watchdog turn-on missing");
  a_unsync_edt: assert property (@(posedge clk_sys) disable iff (reset || supply_reset)
    st_r == vcdt_pkg::ST_EDT && edt_cnt_r == 10'h1 && !unsync && dt_cnt_r < vcdt_pkg::DT_CLAMP_CYC - 10'h1 |=>
    !switch_on && st_r == vcdt_pkg::ST_SYNC)
    else $error("synchronised extra dead time turned on early");
  a_fault_blocks: assert property (@(posedge clk_sys) disable iff (reset)
    (open_r || short_r) |-> !switching_enabled ##1 !switch_on)
    else $error("switching despite latched pin fault");
  a_probe_window: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(sense_resistor_probe_on) |-> sense_resistor_probe_on [*8] ##1 !switching_enabled)
    else $error("probe source not held during identification");
  c_edt_cycle: cover property (@(posedge clk_sys) disable iff (reset) st_r == vcdt_pkg::ST_EDT ##1 switch_on);
  c_substitute: cover property (@(posedge clk_sys) disable iff (reset) subst_fire);
  c_valley_six: cover property (@(posedge clk_sys) disable iff (reset) valley_r == vcdt_pkg::VALLEY_MAX);
  c_open_fault: cover property (@(posedge clk_sys) disable iff (reset) $rose(open_r));
endmodule : vcdt_ctrl
`default_nettype wire

/* verification/vcdt_partner.sv */
// Purpose: far side model, power stage turn-off and demag ringing
// Assumes: each switch_on pulse starts one switching cycle
// Notes: ringing stops after ring_count falls, as with weak ringing
`timescale 1ns/1ps
`default_nettype none
module vcdt_partner (
  input wire logic clk_sys,
  input wire logic switch_on,
  input wire logic [9:0] ring_period,
  input wire logic [2:0] ring_count,
  output logic on_time_end,
  output logic demag_sense
);
  int cnt = 100000;
  int k;
  int ph;
  logic ote_r = 1'b0;
  logic demag_r = 1'b0;
  assign on_time_end = ote_r;
  assign demag_sense = demag_r;
  // fixed 20 cycle on-time, 20 cycle demag, then ringing
  always @(posedge clk_sys) begin
    if (switch_on) begin
      cnt <= 0;
    end else if (cnt < 100000) begin
      cnt <= cnt + 1;
    end
    ote_r <= (cnt == 19) && !switch_on;
    k = (cnt - 40) / int'(ring_period);
    ph = (cnt - 40) % int'(ring_period);
    if (switch_on || cnt < 19) begin
      demag_r <= 1'b0;
    end else if (cnt < 39 || ring_count == 3'h0) begin
      // no ringing: line stays high, only the watchdog ends the cycle
      demag_r <= 1'b1;
    end else begin
      demag_r <= (k < int'(ring_count) - 1) && (ph >= int'(ring_period) / 2);
    end
  end
endmodule : vcdt_partner
`default_nettype wire

/* verification/valley_count_dead_time_ctrl_tb.sv */
// Purpose: self-checking bench for vcdt_ctrl
// Assumes: zero wait state apb, watchdog shortened to 200 cycles
// Notes: timing windows allow for the input synchroniser latency
`timescale 1ns/1ps
`default_nettype none
module valley_count_dead_time_ctrl_tb;
  localparam int WDOG = 200;
  // about 25 switching cycles of at most 1100 clocks each
  localparam int LIMIT = 80000;
  logic clk_sys = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, rerr, demag_sense, on_time_end, sense_resistor_probe_on, switch_on, switching_enabled;
  logic supply_on = 1'b0, supply_reset = 1'b0, demag_q = 1'b0;
  logic [4:0] fold_below_fall = 5'h00, fold_above_rise = 5'h00, edt_level = 5'h00, probe_above_ref = 5'h00;
  logic [1:0] foldback_select;
  logic [9:0] ring_period = 10'h028;
  logic [2:0] ring_count = 3'h6;
  int err_total = 0, num_checks = 0, cyc = 0, n_on = 0, falls = 0, edges_at_on = 0;
  int t_ote = 0, t_first = 0, t_last = 0, t_on = 0, v, pc, n0;

  always #20 clk_sys = ~clk_sys;

  vcdt_ctrl #(.WDOG_CYC(WDOG)) vcdt_ctrl_inst (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .supply_on, .supply_reset, .demag_sense, .on_time_end, .fold_below_fall,
    .fold_above_rise, .edt_level, .probe_above_ref, .sense_resistor_probe_on, .foldback_select, .switch_on,
    .switching_enabled);
  vcdt_partner vcdt_partner_inst (.clk_sys, .switch_on, .ring_period, .ring_count, .on_time_end, .demag_sense);

  // cycle stamps of switching events
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    demag_q <= demag_sense;
    if (on_time_end) begin
      t_ote <= cyc;
      falls <= 0;
    end else if (demag_q && !demag_sense) begin
      falls <= falls + 1;
      t_last <= cyc;
      if (falls == 0) t_first <= cyc;
    end
    if (switch_on) begin
      n_on <= n_on + 1;
      t_on <= cyc;
      edges_at_on <= falls;
    end
    if (cyc == LIMIT) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic rng(input int val, input int lo, input int hi);
    check({31'h0, val >= lo && val <= hi}, 32'h1);
  endtask : rng

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic status_valley(input int exp);
    apb(1'b0, vcdt_pkg::REG_STATUS, 32'h0);
    check({29'h0, rdat[2:0]}, 32'(exp));
  endtask : status_valley

  // sel: 0 last fall, 1 first fall, 2 on_time_end; edges below 0 skips the count
  task automatic turn_on(input int edges, input int sel, input int lo, input int hi);
    int m;
    m = n_on;
    while (n_on == m) @(posedge clk_sys);
    if (edges >= 0) check(32'(edges_at_on), 32'(edges));
    rng(t_on - (sel == 0 ? t_last : (sel == 1 ? t_first : t_ote)), lo, hi);
  endtask : turn_on

  task automatic supply_cycle();
    supply_on <= 1'b0;
    supply_reset <= 1'b1;
    repeat (3) @(posedge clk_sys);
    supply_reset <= 1'b0;
  endtask : supply_cycle

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    apb(1'b0, vcdt_pkg::REG_CTRL, 32'h0);
    check(rdat, vcdt_pkg::CTRL_RESET);
    check({31'h0, pready}, 32'h1);
    apb(1'b0, vcdt_pkg::REG_STATUS, 32'h0);
    check(rdat, 32'h0000_0031);
    apb(1'b0, 8'h0c, 32'h0);
    check({31'h0, rerr}, 32'h1);
    apb(1'b1, vcdt_pkg::REG_CTRL, 32'hffff_ffff);
    apb(1'b0, vcdt_pkg::REG_CTRL, 32'h0);
    check(rdat, 32'h1);
    apb(1'b1, vcdt_pkg::REG_CTRL, 32'h0);
    // faults: short first, then open; both latched until supply reset
    for (int i = 0; i < 2; i++) begin
      probe_above_ref <= (i == 1) ? 5'h1f : 5'h00;
      supply_on <= 1'b1;
      n0 = n_on;
      repeat (300) @(posedge clk_sys);
      check(32'(n_on), 32'(n0));
      supply_on <= 1'b0;
      repeat (20) @(posedge clk_sys);
      apb(1'b0, vcdt_pkg::REG_STATUS, 32'h0);
      check({30'h0, rdat[7:6]}, (i == 1) ? 32'h1 : 32'h2);
      supply_cycle();
      apb(1'b0, vcdt_pkg::REG_STATUS, 32'h0);
      check({30'h0, rdat[7:6]}, 32'h0);
    end
    // every resistor code, the last one left running
    for (int i = 0; i < 4; i++) begin
      probe_above_ref <= 5'((5'h01 << (i + 1)) - 5'h01);
      supply_on <= 1'b1;
      while (sense_resistor_probe_on !== 1'b1) @(posedge clk_sys);
      pc = 0;
      n0 = n_on;
      while (sense_resistor_probe_on === 1'b1) begin
        @(posedge clk_sys);
        pc++;
      end
      rng(pc, 249, 251);
      check(32'(n_on), 32'(n0));
      turn_on(-1, 2, -LIMIT, LIMIT);
      check({30'h0, foldback_select}, 32'(i));
      check({31'h0, switching_enabled}, 32'h1);
      if (i < 3) supply_cycle();
    end
    turn_on(1, 0, 1, 8);
    status_valley(1);
    fold_below_fall <= 5'h1f;
    v = 1;
    for (int i = 0; i < 6; i++) begin
      turn_on(v, 0, 1, 8);
      v = (v < 6) ? v + 1 : 6;
      status_valley(v);
    end
    // boundary 5 to 6 crossed downward only: valley must hold
    fold_below_fall <= 5'h10;
    turn_on(6, 0, 1, 8);
    status_valley(6);
    apb(1'b0, vcdt_pkg::REG_INTERVAL, 32'h0);
    check({22'h0, rdat[9:0]}, 32'h28);
    ring_count <= 3'h1;
    turn_on(1, 0, 253, 261);
    ring_count <= 3'h2;
    turn_on(2, 0, 188, 196);
    ring_count <= 3'h7;
    edt_level <= 5'h02;
    turn_on(7, 0, 1, 8);
    apb(1'b1, vcdt_pkg::REG_CTRL, 32'h1);
    turn_on(6, 0, 32, 40);
    // six falls only: a seventh would land inside the longer extra dead time
    ring_count <= 3'h6;
    edt_level <= 5'h04;
    turn_on(6, 0, 64, 72);
    apb(1'b1, vcdt_pkg::REG_CTRL, 32'h0);
    ring_period <= 10'h064;
    ring_count <= 3'h6;
    edt_level <= 5'h1f;
    turn_on(6, 1, 912, 920);
    ring_period <= 10'h028;
    ring_count <= 3'h0;
    edt_level <= 5'h00;
    turn_on(0, 2, 199, 206);
    ring_count <= 3'h6;
    fold_below_fall <= 5'h00;
    fold_above_rise <= 5'h1f;
    v = 6;
    for (int i = 0; i < 6; i++) begin
      turn_on(v, 0, 1, 8);
      v = (v > 1) ? v - 1 : 1;
      status_valley(v);
    end
    end_of_test();
  end
endmodule : valley_count_dead_time_ctrl_tb
`default_nettype wire
